// File: hdl/bbc_defs.svh
// Constants for the bus bar channel handling block
`ifndef BBC_DEFS_SVH
`define BBC_DEFS_SVH

`define BBC_NCH 16
`define BBC_CODE_W 16
// Register word indexes
`define BBC_A_CTRL 4'h0
`define BBC_A_POSU 4'h1
`define BBC_A_POSL 4'h2
`define BBC_A_SHLOC 4'h3
`define BBC_A_THR 4'h4
`define BBC_A_STAT 4'h5
`define BBC_A_MASK 4'h6
`define BBC_A_RES1 4'h7
`define BBC_A_RES2 4'h8
`define BBC_A_CBEN 4'h9
`define BBC_A_EXCL 4'hA
// Control fields
`define BBC_CTRL_W 9
`define BBC_C_SINK 1:0
`define BBC_C_OVER_UNDER_VOLTAGE_PROTECTOR 2
`define BBC_C_CONV 3
`define BBC_C_GO 4
`define BBC_C_PAUSE 5
`define BBC_C_LPF 8:6
`define BBC_SINK_BB 2'h3
// Status bits
`define BBC_ST_W 8
`define BBC_S_ABORT 0
`define BBC_S_DRDY_AUX 1
`define BBC_S_DRDY_CB 2
`define BBC_S_CMPF 3
`define BBC_S_BBF 4
`define BBC_S_OV 5
`define BBC_S_UV 6
`define BBC_S_CBDONE 7
// Reset and forced values
`define BBC_RES_ABORT 8'hFF
`define BBC_THR_RST 16'h0040
`define BBC_LAST_CH 4'hF

`endif

// File: hdl/bbc_pkg.sv
// Types for the bus bar channel handling block
`default_nettype none
`include "bbc_defs.svh"
package bbc_pkg;
    typedef enum logic [1:0] {
        CMP_IDLE = 2'b00,
        CMP_RUN = 2'b01,
        CMP_BB = 2'b10
    } bbc_cmp_t;

    typedef struct packed {
        logic waitQ;
        logic [31:0] rdata;
        logic [`BBC_CTRL_W-1:0] ctrl;
        logic [7:0] posU;
        logic [7:0] posL;
        logic [4:0] shLoc;
        logic [15:0] thr;
        logic [`BBC_ST_W-1:0] stat;
        logic [`BBC_ST_W-1:0] mask;
        logic [7:0] res1;
        logic [7:0] res2;
        logic [`BBC_NCH-1:0] cbOn;
        logic [`BBC_NCH-1:0] fault;
        bbc_cmp_t st;
        logic [3:0] cnt;
        logic signed [16:0] accM;
        logic signed [16:0] accA;
        logic irq;
        logic cellWe;
        logic [3:0] cellChan;
        logic [15:0] cellCode;
        logic sinkEn;
        logic convEn;
        logic cmEn;
        logic [3:0] cmChan;
    } bbc_state_t;

    typedef struct packed {
        logic [`BBC_NCH-1:0] excl;
        logic valid;
    } bbc_chk_t;
endpackage
`default_nettype wire

// File: hdl/bbc_pos_if.sv
// Position masks between the register block and the position checker
`default_nettype none
`include "bbc_defs.svh"
interface bbc_pos_if;
    logic [`BBC_NCH-1:0] posMask;
    logic [`BBC_NCH-1:0] exclMask;
    logic posValid;
    modport owner (output posMask, input exclMask, input posValid);
    modport check (input posMask, output exclMask, output posValid);
endinterface
`default_nettype wire

// File: hdl/bbc_pos_check.sv
// Bus bar position checker: exclusion mask and legality of the marking
`default_nettype none
`include "bbc_defs.svh"
module bbc_pos_check (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Position masks
    bbc_pos_if.check pos
);
    bbc_pkg::bbc_chk_t s_q;
    bbc_pkg::bbc_chk_t s_d;

    // Count of marked channels
    function automatic logic [4:0] popCount(input logic [`BBC_NCH-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < `BBC_NCH; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

    // Bit i is channel i+1, so the mask is used as is
    always_comb begin
        s_d.excl = pos.posMask;
        s_d.valid = !pos.posMask[0]
            && ((pos.posMask & (pos.posMask >> 1)) == '0)
            && (popCount(pos.posMask) <= 5'h02);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pos.exclMask = s_q.excl;
    assign pos.posValid = s_q.valid;
endmodule // bbc_pos_check
`default_nettype wire

// File: hdl/bbc_top.sv
// Bus bar channel handling: registers, comparison engine, balancing and protection
`default_nettype none
`include "bbc_defs.svh"
module bbc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave, word addressed
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // Comparison read port into the result store
    output logic [3:0] cmpChan,
    input wire logic [15:0] mainCellCode,
    input wire logic [15:0] auxCellCode,
    input wire logic [15:0] bbMainCode,
    input wire logic [15:0] bbAuxCode,
    // Main converter cell results
    input wire logic mainValid,
    input wire logic [3:0] mainChan,
    input wire logic [15:0] mainCode,
    output logic cellWe,
    output logic [3:0] cellChan,
    output logic [15:0] cellCode,
    output logic [2:0] cellLpfSel,
    // Protector comparators
    input wire logic [`BBC_NCH-1:0] ovRaw,
    input wire logic [`BBC_NCH-1:0] uvRaw,
    // Balancing
    input wire logic [`BBC_NCH-1:0] cbTimerExpired,
    input wire logic [`BBC_NCH-1:0] balanceVoltageReached,
    output logic [`BBC_NCH-1:0] balanceSwitch,
    // Analog front-end controls
    output logic mainBbMeasEn,
    output logic auxBbMeasEn,
    output logic busbarSinkEn,
    output logic cmCorrEn,
    output logic [3:0] cmCorrChan
);
    bbc_pkg::bbc_state_t s_q;
    bbc_pkg::bbc_state_t s_d;
    bbc_pos_if posBus ();

    // Magnitude of a signed difference, saturated to 16 bits
    function automatic logic [15:0] absDiff(input logic signed [16:0] a,
                                            input logic signed [16:0] b);
        logic signed [17:0] d;
        d = 18'(a) - 18'(b);
        if (d < 0) begin
            d = -d;
        end
        if (d > 18'sh0FFFF) begin
            return 16'hFFFF;
        end
        return d[15:0];
    endfunction

    // Legality and exclusion of the marked channels
    bbc_pos_check u_check (
        .clk(clk),
        .reset(reset),
        .pos(posBus.check)
    );
    assign posBus.posMask = {s_q.posU, s_q.posL};

    always_comb begin
        logic acc;
        logic wr;
        logic [`BBC_ST_W-1:0] set;
        logic [`BBC_ST_W-1:0] clr;
        logic [`BBC_NCH-1:0] excl;
        logic [`BBC_NCH-1:0] stop;
        logic signed [16:0] mv;
        logic signed [16:0] av;
        acc = 1'b0;
        wr = 1'b0;
        set = '0;
        clr = '0;
        excl = posBus.exclMask;
        stop = '0;
        mv = '0;
        av = '0;
        s_d = s_q;

        // Bus handshake: request seen, then one answer cycle
        acc = (read || write) && !s_q.waitQ;
        wr = write && acc;
        if ((read || write) && s_q.waitQ) begin
            s_d.waitQ = 1'b0;
        end else begin
            s_d.waitQ = 1'b1;
        end
        // Read data is loaded while the answer is prepared
        if (read && s_q.waitQ) begin
            case (address)
                `BBC_A_CTRL: s_d.rdata = 32'({s_q.ctrl});
                `BBC_A_POSU: s_d.rdata = 32'({s_q.posU});
                `BBC_A_POSL: s_d.rdata = 32'({s_q.posL});
                `BBC_A_SHLOC: s_d.rdata = 32'({s_q.shLoc});
                `BBC_A_THR: s_d.rdata = 32'({s_q.thr});
                `BBC_A_STAT: s_d.rdata = 32'({s_q.stat});
                `BBC_A_MASK: s_d.rdata = 32'({s_q.mask});
                `BBC_A_RES1: s_d.rdata = 32'({s_q.res1});
                `BBC_A_RES2: s_d.rdata = 32'({s_q.res2});
                `BBC_A_CBEN: s_d.rdata = 32'({s_q.cbOn});
                `BBC_A_EXCL: s_d.rdata = 32'({posBus.posValid, excl});
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes take effect at the answer edge
        if (wr) begin
            case (address)
                `BBC_A_CTRL: s_d.ctrl = writedata[`BBC_CTRL_W-1:0];
                `BBC_A_POSU: s_d.posU = writedata[7:0];
                `BBC_A_POSL: s_d.posL = writedata[7:0];
                `BBC_A_SHLOC: s_d.shLoc = writedata[4:0];
                `BBC_A_THR: s_d.thr = writedata[15:0];
                `BBC_A_STAT: clr = writedata[`BBC_ST_W-1:0];
                `BBC_A_MASK: s_d.mask = writedata[`BBC_ST_W-1:0];
                `BBC_A_CBEN: s_d.cbOn = writedata[`BBC_NCH-1:0];
                default: ;
            endcase
        end
        // Go is a strobe; it never reads back as set
        s_d.ctrl[`BBC_C_GO] = 1'b0;

        // Comparison engine
        case (s_q.st)
            bbc_pkg::CMP_IDLE: begin
                if (wr && address == `BBC_A_CTRL && writedata[`BBC_C_GO]) begin
                    // Illegal marking or stopped converters refuse the run
                    if (!posBus.posValid || !s_q.ctrl[`BBC_C_CONV]) begin
                        set[`BBC_S_ABORT] = 1'b1;
                        set[`BBC_S_DRDY_AUX] = 1'b1;
                        set[`BBC_S_DRDY_CB] = 1'b1;
                        s_d.res1 = `BBC_RES_ABORT;
                        s_d.res2 = `BBC_RES_ABORT;
                    end else begin
                        s_d.st = bbc_pkg::CMP_RUN;
                        s_d.cnt = '0;
                        s_d.fault = '0;
                        s_d.accM = '0;
                        s_d.accA = '0;
                    end
                end
            end
            bbc_pkg::CMP_RUN: begin
                // Channel above a marked one is compared with the marked channel's codes added in
                mv = 17'(signed'(mainCellCode)) + s_q.accM;
                av = 17'(signed'(auxCellCode)) + s_q.accA;
                if (excl[s_q.cnt]) begin
                    // Balance path of a bus bar channel is open: fold into next cell
                    s_d.accM = 17'(signed'(mainCellCode));
                    s_d.accA = 17'(signed'(auxCellCode));
                end else begin
                    s_d.accM = '0;
                    s_d.accA = '0;
                    s_d.fault[s_q.cnt] = absDiff(mv, av) > s_q.thr;
                end
                if (s_q.cnt == `BBC_LAST_CH) begin
                    s_d.st = bbc_pkg::CMP_BB;
                end else begin
                    s_d.cnt = s_q.cnt + 4'h1;
                end
            end
            bbc_pkg::CMP_BB: begin
                // Dedicated bus bar channel: main against auxiliary result
                set[`BBC_S_BBF] = absDiff(17'(signed'(bbMainCode)),
                                          17'(signed'(bbAuxCode))) > s_q.thr;
                set[`BBC_S_CMPF] = |s_q.fault;
                set[`BBC_S_DRDY_AUX] = 1'b1;
                set[`BBC_S_DRDY_CB] = 1'b1;
                s_d.res1 = s_q.fault[7:0];
                s_d.res2 = s_q.fault[15:8];
                s_d.st = bbc_pkg::CMP_IDLE;
            end
            default: s_d.st = bbc_pkg::CMP_IDLE;
        endcase

        // Protectors ignore marked channels
        if (s_q.ctrl[`BBC_C_OVER_UNDER_VOLTAGE_PROTECTOR]) begin
            set[`BBC_S_OV] = |(ovRaw & ~excl);
            set[`BBC_S_UV] = |(uvRaw & ~excl);
        end

        // Balancing stops on timer or voltage, whichever first; paused holds all
        stop = cbTimerExpired;
        stop = stop | (balanceVoltageReached & ~excl);
        if (!s_q.ctrl[`BBC_C_PAUSE] && !(wr && address == `BBC_A_CBEN)) begin
            // Bus bar channel switch only leaves on its own timer
            s_d.cbOn = s_q.cbOn & ~stop;
            set[`BBC_S_CBDONE] = (s_q.cbOn != '0) && (s_d.cbOn == '0);
        end

        // Sticky status: a new event wins over a clear in the same cycle
        s_d.stat = (s_q.stat & ~clr) | set;
        s_d.irq = |(s_d.stat & s_d.mask);

        // Cell results pass on unchanged, bus bar channel included
        s_d.cellWe = mainValid;
        s_d.cellChan = mainChan;
        s_d.cellCode = mainCode;

        // Front-end controls follow the settings
        s_d.convEn = s_d.ctrl[`BBC_C_CONV];
        s_d.sinkEn = s_d.ctrl[`BBC_C_SINK] == `BBC_SINK_BB;
        s_d.cmEn = s_d.shLoc != 5'h00;
        s_d.cmChan = 4'(s_d.shLoc - 5'h01);
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.waitQ <= 1'b1;
            s_q.thr <= `BBC_THR_RST;
            s_q.st <= bbc_pkg::CMP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign readdata = s_q.rdata;
    assign waitrequest = s_q.waitQ;
    assign irq = s_q.irq;
    assign cmpChan = s_q.cnt;
    assign cellWe = s_q.cellWe;
    assign cellChan = s_q.cellChan;
    assign cellCode = s_q.cellCode;
    assign cellLpfSel = s_q.ctrl[`BBC_C_LPF];
    assign balanceSwitch = s_q.cbOn;
    assign mainBbMeasEn = s_q.convEn;
    assign auxBbMeasEn = s_q.convEn;
    assign busbarSinkEn = s_q.sinkEn;
    assign cmCorrEn = s_q.cmEn;
    assign cmCorrChan = s_q.cmChan;
endmodule // bbc_top
`default_nettype wire

// File: bench/bbc_afe_model.sv
// Result store and bus bar front end model seen by the compare engine
`default_nettype none
`include "bbc_defs.svh"
module bbc_afe_model (
    // Compare read port
    input wire logic [3:0] cmpChan,
    // Fault injection from the bench
    input wire logic [`BBC_NCH-1:0] faultMask,
    input wire logic bbFault,
    input wire logic [15:0] delta,
    // Codes back to the block
    output logic [15:0] mainCellCode,
    output logic [15:0] auxCellCode,
    output logic [15:0] bbMainCode,
    output logic [15:0] bbAuxCode
);
    timeunit 1ns;
    timeprecision 100ps;
    // Distinct code per channel, so a wrong pairing shows in the result bits
    always_comb begin
        mainCellCode = 16'h1000 + {8'h00, cmpChan, 4'h0};
        auxCellCode = mainCellCode + (faultMask[cmpChan] ? delta : 16'h0000);
    end
    // Dedicated pair read by both converters; aux skewed only when asked
    assign bbMainCode = 16'h0100;
    assign bbAuxCode = 16'h0100 + (bbFault ? delta : 16'h0000);
endmodule // bbc_afe_model
`default_nettype wire

// File: bench/bbc_top_chk.sv
// Port-level assertions for the bus bar channel handling block
`default_nettype none
`include "bbc_defs.svh"
module bbc_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic irq,
    // Compare and cell results
    input wire logic [3:0] cmpChan,
    input wire logic mainValid,
    input wire logic [3:0] mainChan,
    input wire logic [15:0] mainCode,
    input wire logic cellWe,
    input wire logic [3:0] cellChan,
    input wire logic [15:0] cellCode,
    input wire logic [2:0] cellLpfSel,
    // Balancing
    input wire logic [`BBC_NCH-1:0] cbTimerExpired,
    input wire logic [`BBC_NCH-1:0] balanceVoltageReached,
    input wire logic [`BBC_NCH-1:0] balanceSwitch,
    // Front-end controls
    input wire logic mainBbMeasEn,
    input wire logic auxBbMeasEn,
    input wire logic busbarSinkEn,
    input wire logic cmCorrEn,
    input wire logic [3:0] cmCorrChan
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Accepted writes to the three configuration words
    logic ctrlWr, locWr, cbenWr;
    assign ctrlWr = write && !waitrequest && address == `BBC_A_CTRL;
    assign locWr = write && !waitrequest && address == `BBC_A_SHLOC;
    assign cbenWr = write && !waitrequest && address == `BBC_A_CBEN;
    // Bus answers after exactly one wait cycle and stands one cycle
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) // Bus
        else $error("waitrequest did not drop after one cycle");
    a_wait_stand: assert property (!waitrequest |=> waitrequest) // Bus
        else $error("waitrequest low for more than one cycle");
    a_cell_copy: assert property (mainValid |=> cellWe && cellChan == $past(mainChan)
        && cellCode == $past(mainCode)) else $error("cell result not copied");
    a_cell_quiet: assert property (!mainValid |=> !cellWe)
        else $error("cell write without a result strobe");
    a_sink_ctrl: assert property (ctrlWr |-> ##2
        busbarSinkEn == ($past(writedata[1:0], 2) == `BBC_SINK_BB))
        else $error("bus bar sink enable wrong");
    a_meas_ctrl: assert property (ctrlWr |-> ##2 mainBbMeasEn == $past(writedata[3], 2)
        && auxBbMeasEn == $past(writedata[3], 2)) else $error("bus bar measure enable wrong");
    a_lpf_ctrl: assert property (ctrlWr |-> ##2 cellLpfSel == $past(writedata[8:6], 2))
        else $error("cell filter setting wrong");
    a_cm_loc: assert property (locWr |-> ##2 cmCorrEn == ($past(writedata[4:0], 2) != 5'h00)
        && (!cmCorrEn || cmCorrChan == $past(writedata[3:0], 2) - 4'h1))
        else $error("common-mode channel wrong");
    a_cmp_walk: assert property ($changed(cmpChan) && cmpChan != 4'h0
        |-> cmpChan == $past(cmpChan) + 4'h1) else $error("compare channel skipped");
    a_sw_cause: assert property (!$past(cbenWr) |-> ($past(balanceSwitch) & ~balanceSwitch
        & ~$past(cbTimerExpired | balanceVoltageReached)) == '0)
        else $error("balance switch dropped without cause");
    // Main scenarios reached
    c_cell: cover property (mainValid);
    c_irq: cover property ($rose(irq));
    c_last: cover property (cmpChan == `BBC_LAST_CH);
    c_sw_off: cover property ($fell(balanceSwitch[1]));
endmodule // bbc_top_chk
`default_nettype wire

// File: bench/bbc_top_tb_top.sv
// Self-checking testbench for the bus bar channel handling block
`default_nettype none
`include "bbc_defs.svh"
module bbc_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic mainValid = 1'b0;
    logic [3:0] mainChan = 4'h0;
    logic [15:0] mainCode = 16'h0;
    logic [`BBC_NCH-1:0] ovRaw = '0, uvRaw = '0, cbTimerExpired = '0, balanceVoltageReached = '0;
    logic [`BBC_NCH-1:0] faultMask = '0;
    logic bbFault = 1'b0;
    logic [31:0] readdata, q;
    logic waitrequest, irq, cellWe, mainBbMeasEn, auxBbMeasEn, busbarSinkEn, cmCorrEn;
    logic [3:0] cmpChan, cellChan, cmCorrChan;
    logic [15:0] mainCellCode, auxCellCode, bbMainCode, bbAuxCode, cellCode;
    logic [2:0] cellLpfSel;
    logic [`BBC_NCH-1:0] balanceSwitch;
    logic [15:0] badPos [4] = '{16'h0001, 16'h0006, 16'h2222, 16'h0004};
    int err_total = 0;
    int n_tests = 0;
    int n;
    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;
    bbc_top u_dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .cmpChan(cmpChan), .mainCellCode(mainCellCode), .auxCellCode(auxCellCode),
        .bbMainCode(bbMainCode), .bbAuxCode(bbAuxCode), .mainValid(mainValid),
        .mainChan(mainChan), .mainCode(mainCode), .cellWe(cellWe), .cellChan(cellChan),
        .cellCode(cellCode), .cellLpfSel(cellLpfSel), .ovRaw(ovRaw), .uvRaw(uvRaw),
        .cbTimerExpired(cbTimerExpired), .balanceVoltageReached(balanceVoltageReached),
        .balanceSwitch(balanceSwitch), .mainBbMeasEn(mainBbMeasEn), .auxBbMeasEn(auxBbMeasEn),
        .busbarSinkEn(busbarSinkEn), .cmCorrEn(cmCorrEn), .cmCorrChan(cmCorrChan));
    bbc_afe_model u_afe (.cmpChan(cmpChan), .faultMask(faultMask), .bbFault(bbFault),
        .delta(16'h0100), .mainCellCode(mainCellCode), .auxCellCode(auxCellCode),
        .bbMainCode(bbMainCode), .bbAuxCode(bbAuxCode));
    // Verdict and end of run, shared by the tests and the watchdog
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer; held until waitrequest is sampled low, then one idle cycle
    // No local limit: only the watchdog ends a hung wait, and it counts a mismatch
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
            output logic [31:0] r);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask
    // Watchdog: whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped index, read-only result word
        rd(`BBC_A_THR, q); chk(q, 32'h0000_0040);
        rd(4'hB, q); chk(q, 32'h0);
        wr(`BBC_A_RES1, 32'h0000_00FF); rd(`BBC_A_RES1, q); chk(q, 32'h0);
        // Illegal markings and converters off: start refused
        for (int i = 0; i < 4; i++) begin
            wr(`BBC_A_POSL, {24'h0, badPos[i][7:0]});
            wr(`BBC_A_POSU, {24'h0, badPos[i][15:8]});
            // Converter state is judged before the go write lands, so set it first
            wr(`BBC_A_CTRL, (i == 3) ? 32'h00 : 32'h08);
            wr(`BBC_A_CTRL, (i == 3) ? 32'h10 : 32'h18);
            rd(`BBC_A_STAT, q); chk(q, 32'h07);
            rd(`BBC_A_RES1, q); chk(q, 32'hFF);
            rd(`BBC_A_RES2, q); chk(q, 32'hFF);
            wr(`BBC_A_STAT, 32'hFF);
        end
        // Legal marking: channel 2 only, set well before the start
        wr(`BBC_A_POSU, 32'h0);
        wr(`BBC_A_POSL, 32'h02);
        wr(`BBC_A_MASK, 32'h10);
        rd(`BBC_A_EXCL, q); chk(q, 32'h0001_0002);
        faultMask <= 16'h0202;
        bbFault <= 1'b1;
        wr(`BBC_A_CTRL, 32'h08);
        wr(`BBC_A_CTRL, 32'h18);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(32'(irq), 32'h1);
        // Marked channel folded into the one above; own bit stays clear
        rd(`BBC_A_STAT, q); chk(q, 32'h1E);
        rd(`BBC_A_RES1, q); chk(q, 32'h04);
        rd(`BBC_A_RES2, q); chk(q, 32'h02);
        // Masked bits keep irq low once the enabled one is cleared
        wr(`BBC_A_STAT, 32'h10);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        wr(`BBC_A_STAT, 32'hFF);
        faultMask <= '0;
        bbFault <= 1'b0;
        // Balancing across the marked channel: voltage stops the neighbour, only the timer stops the marked switch
        wr(`BBC_A_CBEN, 32'h0006);
        balanceVoltageReached <= 16'h0006;
        repeat (3) @(posedge clk);
        rd(`BBC_A_CBEN, q); chk(q, 32'h0002);
        cbTimerExpired <= 16'h0002;
        repeat (3) @(posedge clk);
        chk(32'(balanceSwitch), 32'h0);
        rd(`BBC_A_STAT, q); chk(q, 32'h80);
        balanceVoltageReached <= '0;
        cbTimerExpired <= '0;
        wr(`BBC_A_STAT, 32'hFF);
        // Protectors ignore the marked channel only
        wr(`BBC_A_CTRL, 32'h0C);
        ovRaw <= 16'h0002;
        uvRaw <= 16'h0002;
        repeat (3) @(posedge clk);
        rd(`BBC_A_STAT, q); chk(q, 32'h00);
        ovRaw <= 16'h0008;
        uvRaw <= 16'h0010;
        repeat (3) @(posedge clk);
        rd(`BBC_A_STAT, q); chk(q, 32'h60);
        ovRaw <= '0;
        uvRaw <= '0;
        // Front-end controls from the control and location words
        wr(`BBC_A_CTRL, 32'h14B);
        chk(32'({busbarSinkEn, mainBbMeasEn, auxBbMeasEn, cellLpfSel}), 32'h3D);
        wr(`BBC_A_CTRL, 32'h002);
        chk(32'(busbarSinkEn), 32'h0);
        wr(`BBC_A_SHLOC, 32'h05);
        chk(32'({cmCorrEn, cmCorrChan}), 32'h14);
        // Main converter result lands in its channel's result pair
        mainChan <= 4'h3;
        mainCode <= 16'h1234;
        mainValid <= 1'b1;
        @(posedge clk);
        mainValid <= 1'b0;
        @(posedge clk);
        chk(32'({cellWe, cellChan, cellCode}), 32'h1_3123_4);
        summarize();
    end
endmodule // bbc_top_tb_top
bind bbc_top bbc_top_chk u_chk (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .waitrequest(waitrequest), .irq(irq),
    .cmpChan(cmpChan), .mainValid(mainValid), .mainChan(mainChan), .mainCode(mainCode),
    .cellWe(cellWe), .cellChan(cellChan), .cellCode(cellCode), .cellLpfSel(cellLpfSel),
    .cbTimerExpired(cbTimerExpired), .balanceVoltageReached(balanceVoltageReached),
    .balanceSwitch(balanceSwitch), .mainBbMeasEn(mainBbMeasEn), .auxBbMeasEn(auxBbMeasEn),
    .busbarSinkEn(busbarSinkEn), .cmCorrEn(cmCorrEn), .cmCorrChan(cmCorrChan));
`default_nettype wire
